// ===== bit_sync.sv
// Two-stage synchroniser for asynchronous inputs
`default_nettype none

module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,   // Sampling clock
    input  wire logic             rst_in,   // Async reset, active high
    input  wire logic [WIDTH-1:0] d_in,     // Asynchronous level
    output logic      [WIDTH-1:0] q_out     // Synchronised level
);
    logic [WIDTH-1:0] meta_q;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                meta_q[i] <= 1'b1;
                q_out[i]  <= 1'b1;
            end else begin
                meta_q[i] <= d_in[i];
                q_out[i]  <= meta_q[i];
            end
        end
    end
endmodule : bit_sync

`default_nettype wire

// ===== restart_timer.sv
// Restart interval counter after a wake-up
`include "uart_adpd_map.svh"
`default_nettype none

module restart_timer (
    input  wire logic clk_in,     // System clock
    input  wire logic rst_in,     // Async reset, active high
    input  wire logic start_in,   // Wake-up pulse
    output logic      busy_out,   // High during the restart interval
    output logic      done_out    // One-cycle pulse when it ends
);
    logic [10:0] cnt_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q    <= 11'h000;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                cnt_q    <= `UA_RESTART_CYC - 11'd1;
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (cnt_q == 11'h000) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 11'd1;
                end
            end
        end
    end
endmodule : restart_timer

`default_nettype wire

// ===== serial_node.sv
// Remote serial node driving the block's receive line
`default_nettype none
module serial_node (
    input wire logic clk_in,  // Clock
    output logic     line_out // Idles high, pulled up
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_out = 1'b1;
    // Start, nb data bits LSB first, stop; bt clocks a bit
    task automatic send(input logic [8:0] w, input int nb, input int bt);
        logic [10:0] f;
        f = {1'b1, w, 1'b0};
        f[nb + 1] = 1'b1;
        for (int i = 0; i < nb + 2; i++) begin
            @(posedge clk_in);
            line_out <= f[i];
            repeat (bt - 1) @(posedge clk_in);
        end
    endtask : send
endmodule : serial_node
`default_nettype wire

// ===== uart_adpd.sv
// UART with address-detect interrupt gating and power-down / RX wake-up
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`include "uart_adpd_map.svh"
`default_nettype none

module uart_adpd (
    input  wire logic        sys_clk_in,          // 250 MHz system clock
    input  wire logic        sys_rst_in,          // Async reset, active high
    input  wire logic [7:0]  s_axi_awaddr_in,     // Write address
    input  wire logic        s_axi_awvalid_in,    // Write address valid
    output logic             s_axi_awready_out,   // Write address ready
    input  wire logic [31:0] s_axi_wdata_in,      // Write data
    input  wire logic [3:0]  s_axi_wstrb_in,      // Write byte strobes
    input  wire logic        s_axi_wvalid_in,     // Write data valid
    output logic             s_axi_wready_out,    // Write data ready
    output logic [1:0]       s_axi_bresp_out,     // Write response
    output logic             s_axi_bvalid_out,    // Write response valid
    input  wire logic        s_axi_bready_in,     // Write response ready
    input  wire logic [7:0]  s_axi_araddr_in,     // Read address
    input  wire logic        s_axi_arvalid_in,    // Read address valid
    output logic             s_axi_arready_out,   // Read address ready
    output logic [31:0]      s_axi_rdata_out,     // Read data
    output logic [1:0]       s_axi_rresp_out,     // Read response
    output logic             s_axi_rvalid_out,    // Read data valid
    input  wire logic        s_axi_rready_in,     // Read data ready
    input  wire logic        rx_pin_in,           // Serial receive line
    output logic             tx_pin_out,          // Serial transmit line
    output logic             irq_out,             // UART interrupt, level
    output logic             power_down_out       // Chip held in power-down
);
    uart_adpd_pkg::ctrl_one_t ctrl_one_q;
    uart_adpd_pkg::ctrl_two_t ctrl_two_q;
    uart_adpd_pkg::irq_ctl_t  irq_ctl_q;
    uart_adpd_pkg::tx_state_t tx_st_q;
    uart_adpd_pkg::rx_state_t rx_st_q;

    logic [15:0] baud_divisor;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        aw_got_q;
    logic        w_got_q;
    logic        wr_fire;
    logic        rd_fire;
    logic [1:0]  irq_sts_q;
    logic [1:0]  irq_en_q;
    logic [1:0]  irq_set;
    logic        wake_arm_q;
    logic        wake;
    logic        restart_busy;
    logic        restart_done;
    logic        rx_s;
    logic        rx_prev_q;
    logic        rx_fall;
    logic [8:0]  rx_data_buffer;
    logic        rx_avail_flag;
    logic        rx_addr_word_q;
    logic [8:0]  rx_sh_q;
    logic [3:0]  rx_idx_q;
    logic [15:0] rx_cnt_q;
    logic        rx_done_q;
    logic [10:0] tx_sh_q;
    logic [3:0]  tx_left_q;
    logic [15:0] tx_cnt_q;
    logic        tx_load;
    logic        rx_top;
    logic        rx_halt;

    // Known register address, shared by read and write decode
    function automatic logic reg_mapped(input logic [7:0] a);
        case (a)
            `UA_OFF_STATUS, `UA_OFF_CTRL1, `UA_OFF_CTRL2, `UA_OFF_BAUD,
            `UA_OFF_DATA, `UA_OFF_IRQCTL, `UA_OFF_POWER, `UA_OFF_ISTAT,
            `UA_OFF_ICLR, `UA_OFF_IEN: reg_mapped = 1'b1;
            default: reg_mapped = 1'b0;
        endcase
    endfunction : reg_mapped

    bit_sync #(.WIDTH(1)) u_rx_sync (
        .clk_in (sys_clk_in),
        .rst_in (sys_rst_in),
        .d_in   (rx_pin_in),
        .q_out  (rx_s)
    );

    restart_timer u_restart (
        .clk_in   (sys_clk_in),
        .rst_in   (sys_rst_in),
        .start_in (wake),
        .busy_out (restart_busy),
        .done_out (restart_done)
    );

    // AXI write channel: address and data taken in either order
    assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid_out;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            aw_got_q          <= 1'b0;
            w_got_q           <= 1'b0;
            aw_addr_q         <= 8'h00;
            w_data_q          <= 32'h0000_0000;
            w_strb_q          <= 4'h0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= `UA_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_got_q          <= 1'b1;
                aw_addr_q         <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_got_q          <= 1'b1;
                w_data_q         <= s_axi_wdata_in;
                w_strb_q         <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_q         <= 1'b0;
                w_got_q          <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= reg_mapped({aw_addr_q[7:2], 2'b00}) ?
                                    `UA_RESP_OKAY : `UA_RESP_DECERR;
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out  <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end

    // Software registers; power-down never touches them
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_one_q   <= uart_adpd_pkg::ctrl_one_t'(`UA_CTRL1_RST);
            ctrl_two_q   <= uart_adpd_pkg::ctrl_two_t'(`UA_CTRL2_RST);
            irq_ctl_q    <= uart_adpd_pkg::irq_ctl_t'(`UA_IRQCTL_RST);
            irq_en_q     <= `UA_IEN_RST;
            baud_divisor <= `UA_BAUD_RST;
        end else if (wr_fire) begin
            case ({aw_addr_q[7:2], 2'b00})
                `UA_OFF_CTRL1: if (w_strb_q[0]) begin
                    ctrl_one_q <= uart_adpd_pkg::ctrl_one_t'(w_data_q[2:0]);
                end
                `UA_OFF_CTRL2: if (w_strb_q[0]) begin
                    ctrl_two_q <= uart_adpd_pkg::ctrl_two_t'(w_data_q[4:0]);
                end
                `UA_OFF_IRQCTL: if (w_strb_q[0]) begin
                    irq_ctl_q <= uart_adpd_pkg::irq_ctl_t'(w_data_q[1:0]);
                end
                `UA_OFF_IEN: if (w_strb_q[0]) begin
                    irq_en_q <= w_data_q[1:0];
                end
                `UA_OFF_BAUD: begin
                    if (w_strb_q[0]) begin
                        baud_divisor[7:0] <= w_data_q[7:0];
                    end
                    if (w_strb_q[1]) begin
                        baud_divisor[15:8] <= w_data_q[15:8];
                    end
                end
                default: ;
            endcase
        end
    end

    // Power-down entry by software; wake arming captured at entry
    assign rx_fall = rx_prev_q & ~rx_s;
    assign wake    = power_down_out & wake_arm_q & rx_fall;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            power_down_out <= 1'b0;
            wake_arm_q     <= 1'b0;
            rx_prev_q      <= 1'b1;
        end else begin
            rx_prev_q <= rx_s;
            if (wake) begin
                power_down_out <= 1'b0;
            end else if (wr_fire && {aw_addr_q[7:2], 2'b00} == `UA_OFF_POWER
                         && w_strb_q[0]) begin
                if (w_data_q[0] && !power_down_out) begin
                    wake_arm_q <= ctrl_two_q.wake_en & ctrl_one_q.uart_on
                                & ctrl_two_q.rx_on & ctrl_two_q.rx_irq_en;
                end
                power_down_out <= w_data_q[0];
            end
        end
    end

    // Transmitter; forced to idle in power-down, frozen during restart
    assign tx_load = wr_fire && {aw_addr_q[7:2], 2'b00} == `UA_OFF_DATA && w_strb_q[0]
                   && tx_st_q == uart_adpd_pkg::TX_IDLE && ctrl_one_q.uart_on
                   && ctrl_two_q.tx_on && !power_down_out && !restart_busy;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_st_q    <= uart_adpd_pkg::TX_IDLE;
            tx_sh_q    <= 11'h7ff;
            tx_left_q  <= 4'h0;
            tx_cnt_q   <= 16'h0000;
            tx_pin_out <= 1'b1;
        end else if (power_down_out || !ctrl_one_q.uart_on) begin
            tx_st_q    <= uart_adpd_pkg::TX_IDLE;
            tx_pin_out <= 1'b1;
        end else if (!restart_busy) begin
            case (tx_st_q)
                uart_adpd_pkg::TX_IDLE: begin
                    tx_pin_out <= 1'b1;
                    if (tx_load) begin
                        tx_sh_q   <= ctrl_one_q.nine_bit_sel ?
                                     {1'b1, w_data_q[8:0], 1'b0} :
                                     {2'b11, w_data_q[7:0], 1'b0};
                        tx_left_q <= ctrl_one_q.nine_bit_sel ? 4'd11 : 4'd10;
                        tx_cnt_q  <= 16'h0000;
                        tx_st_q   <= uart_adpd_pkg::TX_SEND;
                    end
                end
                uart_adpd_pkg::TX_SEND: begin
                    tx_pin_out <= tx_sh_q[0];
                    if (tx_cnt_q == baud_divisor) begin
                        tx_cnt_q  <= 16'h0000;
                        tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                        tx_left_q <= tx_left_q - 4'd1;
                        if (tx_left_q == 4'd1) begin
                            tx_st_q <= uart_adpd_pkg::TX_IDLE;
                        end
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 16'd1;
                    end
                end
                default: tx_st_q <= uart_adpd_pkg::TX_IDLE;
            endcase
        end
    end

    // Receiver; held idle while stopped or restarting
    assign rx_halt = power_down_out || restart_busy
                   || !ctrl_one_q.uart_on || !ctrl_two_q.rx_on;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_st_q   <= uart_adpd_pkg::RX_IDLE;
            rx_sh_q   <= 9'h000;
            rx_idx_q  <= 4'h0;
            rx_cnt_q  <= 16'h0000;
            rx_done_q <= 1'b0;
        end else if (rx_halt) begin
            rx_st_q   <= uart_adpd_pkg::RX_IDLE;
            rx_done_q <= 1'b0;
        end else begin
            rx_done_q <= 1'b0;
            case (rx_st_q)
                uart_adpd_pkg::RX_IDLE: begin
                    if (rx_fall) begin
                        rx_cnt_q <= 16'h0000;
                        rx_sh_q  <= 9'h000;
                        rx_st_q  <= uart_adpd_pkg::RX_START;
                    end
                end
                uart_adpd_pkg::RX_START: begin
                    // Mid-bit check rejects glitches shorter than half a bit
                    if (rx_cnt_q == {1'b0, baud_divisor[15:1]}) begin
                        rx_cnt_q <= 16'h0000;
                        rx_idx_q <= 4'h0;
                        rx_st_q  <= rx_s ? uart_adpd_pkg::RX_IDLE
                                         : uart_adpd_pkg::RX_DATA;
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 16'd1;
                    end
                end
                uart_adpd_pkg::RX_DATA: begin
                    if (rx_cnt_q == baud_divisor) begin
                        rx_cnt_q          <= 16'h0000;
                        rx_sh_q[rx_idx_q] <= rx_s;
                        rx_idx_q          <= rx_idx_q + 4'd1;
                        if (rx_idx_q == (ctrl_one_q.nine_bit_sel ? 4'd8 : 4'd7)) begin
                            rx_st_q <= uart_adpd_pkg::RX_STOP;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 16'd1;
                    end
                end
                uart_adpd_pkg::RX_STOP: begin
                    if (rx_cnt_q == baud_divisor) begin
                        rx_done_q <= 1'b1;
                        rx_st_q   <= uart_adpd_pkg::RX_IDLE;
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 16'd1;
                    end
                end
                default: rx_st_q <= uart_adpd_pkg::RX_IDLE;
            endcase
        end
    end

    assign rx_top = ctrl_one_q.nine_bit_sel ? rx_sh_q[8] : rx_sh_q[7];

    // Every word lands in the buffer; a new word beats a same-cycle read
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_data_buffer <= 9'h000;
            rx_avail_flag  <= 1'b0;
            rx_addr_word_q <= 1'b0;
        end else if (rx_done_q) begin
            rx_data_buffer <= rx_sh_q;
            rx_avail_flag  <= 1'b1;
            rx_addr_word_q <= rx_top;
        end else if (rd_fire && {s_axi_araddr_in[7:2], 2'b00} == `UA_OFF_DATA) begin
            rx_avail_flag <= 1'b0;
        end
    end

    // Interrupt status: sticky, set beats clear
    assign irq_set[`UA_IRQ_RX]   = rx_done_q && ctrl_two_q.rx_irq_en
                                 && (!ctrl_two_q.address_match_gate_en || rx_top);
    assign irq_set[`UA_IRQ_WAKE] = restart_done;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_sts_q <= 2'h0;
            irq_out   <= 1'b0;
        end else begin
            if (wr_fire && {aw_addr_q[7:2], 2'b00} == `UA_OFF_ICLR && w_strb_q[0]) begin
                irq_sts_q <= (irq_sts_q & ~w_data_q[1:0]) | irq_set;
            end else begin
                irq_sts_q <= irq_sts_q | irq_set;
            end
            irq_out <= irq_ctl_q.global_irq_en && irq_ctl_q.uart_irq_en
                    && |(irq_sts_q & irq_en_q);
        end
    end

    // AXI read channel; one read at a time
    assign rd_fire = s_axi_arvalid_in & s_axi_arready_out;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= `UA_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rresp_out   <= reg_mapped({s_axi_araddr_in[7:2], 2'b00}) ?
                                 `UA_RESP_OKAY : `UA_RESP_DECERR;
            case ({s_axi_araddr_in[7:2], 2'b00})
                `UA_OFF_STATUS: s_axi_rdata_out <= {26'h0, restart_busy, power_down_out,
                    tx_st_q == uart_adpd_pkg::TX_SEND, rx_st_q == uart_adpd_pkg::RX_IDLE,
                    rx_addr_word_q, rx_avail_flag};
                `UA_OFF_CTRL1:  s_axi_rdata_out <= {29'h0, ctrl_one_q};
                `UA_OFF_CTRL2:  s_axi_rdata_out <= {27'h0, ctrl_two_q};
                `UA_OFF_BAUD:   s_axi_rdata_out <= {16'h0, baud_divisor};
                `UA_OFF_DATA:   s_axi_rdata_out <= {23'h0, rx_data_buffer};
                `UA_OFF_IRQCTL: s_axi_rdata_out <= {30'h0, irq_ctl_q};
                `UA_OFF_POWER:  s_axi_rdata_out <= {31'h0, power_down_out};
                `UA_OFF_ISTAT:  s_axi_rdata_out <= {30'h0, irq_sts_q};
                `UA_OFF_IEN:    s_axi_rdata_out <= {30'h0, irq_en_q};
                default:        s_axi_rdata_out <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end
endmodule : uart_adpd

`default_nettype wire

// ===== uart_adpd_assertions.sv
// Port-level checks for the address-detect and power-down UART
`default_nettype none
module uart_adpd_assertions (
    input wire logic sys_clk_in,        // Clock
    input wire logic sys_rst_in,        // Reset
    input wire logic s_axi_arvalid_in,  // AR valid
    input wire logic s_axi_arready_out, // AR ready
    input wire logic s_axi_awready_out, // AW ready
    input wire logic s_axi_bvalid_out,  // B valid
    input wire logic s_axi_bready_in,   // B ready
    input wire logic s_axi_rvalid_out,  // R valid
    input wire logic rx_pin_in,         // Serial in
    input wire logic tx_pin_out,        // Serial out
    input wire logic irq_out,           // Interrupt
    input wire logic power_down_out     // Power-down
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] quiet_q;
    logic        pd_q;
    logic [2:0]  rx_h;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // Loaded short of 1024 to absorb the wake detector's lag
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pd_q <= 1'b0;
            rx_h <= 3'h7;
            quiet_q <= 11'h000;
        end else begin
            pd_q <= power_down_out;
            rx_h <= {rx_h[1:0], rx_pin_in};
            quiet_q <= (pd_q && !power_down_out && !rx_h[2]) ? 11'h3fc
                     : quiet_q - {10'h000, quiet_q != 11'h000};
        end
    end
    AST_PD_TX_HIGH: assert property (power_down_out && $past(power_down_out) |-> tx_pin_out)
        else $error("tx low in power-down");
    AST_PD_NO_IRQ: assert property (power_down_out |-> !$rose(irq_out))
        else $error("irq rose in power-down");
    AST_RESTART_QUIET: assert property (quiet_q != 11'h000 |-> !$rose(irq_out))
        else $error("irq inside restart interval");
    AST_WAKE_TX_IDLE: assert property ($fell(power_down_out) |-> tx_pin_out [*4])
        else $error("tx resumed a frame");
    AST_BVALID_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("bvalid dropped");
    AST_AW_BLOCKED: assert property (s_axi_bvalid_out |-> !s_axi_awready_out)
        else $error("awready during response");
    AST_READ_ONE: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    AST_AR_BLOCKED: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("arready during read data");
    COV_IRQ: cover property ($rose(irq_out));
    COV_PD: cover property ($rose(power_down_out));
    COV_WAKE: cover property (quiet_q == 11'h3fc);
endmodule : uart_adpd_assertions
`default_nettype wire

// ===== uart_adpd_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef UART_ADPD_MAP_SVH
`define UART_ADPD_MAP_SVH

`define UA_OFF_STATUS   8'h00
`define UA_OFF_CTRL1    8'h04
`define UA_OFF_CTRL2    8'h08
`define UA_OFF_BAUD     8'h0c
`define UA_OFF_DATA     8'h10
`define UA_OFF_IRQCTL   8'h14
`define UA_OFF_POWER    8'h18
`define UA_OFF_ISTAT    8'h1c
`define UA_OFF_ICLR     8'h20
`define UA_OFF_IEN      8'h24

`define UA_CTRL1_RST    3'h0
`define UA_CTRL2_RST    5'h00
`define UA_BAUD_RST     16'h001f
`define UA_IRQCTL_RST   2'h0
`define UA_IEN_RST      2'h0

`define UA_IRQ_RX       0
`define UA_IRQ_WAKE     1

`define UA_RESP_OKAY    2'h0
`define UA_RESP_DECERR  2'h3

`define UA_RESTART_CYC  11'd1024

`endif

// ===== uart_adpd_pkg.sv
// Types shared by the address-detect and power-down UART block
`default_nettype none

package uart_adpd_pkg;

    typedef struct packed {
        logic parity_on;
        logic nine_bit_sel;
        logic uart_on;
    } ctrl_one_t;

    typedef struct packed {
        logic wake_en;
        logic rx_irq_en;
        logic address_match_gate_en;
        logic tx_on;
        logic rx_on;
    } ctrl_two_t;

    typedef struct packed {
        logic uart_irq_en;
        logic global_irq_en;
    } irq_ctl_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } rx_state_t;

endpackage : uart_adpd_pkg

`default_nettype wire

// ===== uart_adpd_test.sv
// Self-checking bench for the address-detect and power-down UART
`include "uart_adpd_map.svh"
`default_nettype none
module uart_adpd_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d;
    logic [3:0]  s_axi_wstrb_in;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r;
    logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
    logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
    logic        s_axi_rvalid_out, s_axi_rready_in, rx_pin_in, tx_pin_out, irq_out;
    logic        power_down_out;
    logic [8:0]  w;
    int          num_errors = 0, compares = 0, seed = 45, cyc = 0, n;
    uart_adpd uart_adpd_inst (.*);
    serial_node serial_node_inst (.clk_in(sys_clk_in), .line_out(rx_pin_in));
    always #2 sys_clk_in = ~sys_clk_in;
    task automatic print_verdict;
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= v;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        do begin
            @(posedge sys_clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (!s_axi_bvalid_out);
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge sys_clk_in);
        s_axi_araddr_in <= a;
        {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
        do begin
            @(posedge sys_clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (!s_axi_rvalid_out);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
        chk(d & m, e);
    endtask : rchk
    function automatic logic irq_exp(input logic gate, input logic nine, input logic [8:0] v);
        return !gate || (nine ? v[8] : v[7]);
    endfunction : irq_exp
    initial begin
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
        {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
        s_axi_wstrb_in = 4'hf;
        repeat (2) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        rchk(`UA_OFF_BAUD, 32'hffffffff, 32'h0000001f);
        wr(`UA_OFF_BAUD, 32'h3);
        wr(`UA_OFF_IRQCTL, 32'h3);
        for (int m = 0; m < 4; m++) begin
            wr(`UA_OFF_CTRL1, {30'h0, m[1], 1'b1});
            wr(`UA_OFF_CTRL2, {27'h0, 2'b01, m[0], 2'b11});
            for (int k = 0; k < 4; k++) begin
                w = 9'($random(seed));
                w[m[1] ? 8 : 7] = k[0];
                wr(`UA_OFF_IEN, {31'h0, k[1]});
                serial_node_inst.send(w, m[1] ? 9 : 8, 4);
                repeat (12) @(posedge sys_clk_in);
                chk(irq_out, irq_exp(m[0], m[1], w) & k[1]);
                rchk(`UA_OFF_ISTAT, 32'h1, {31'h0, irq_exp(m[0], m[1], w)});
                rchk(`UA_OFF_STATUS, 32'h3, {30'h0, k[0], 1'b1});
                rchk(`UA_OFF_DATA, 32'h1ff, {23'h0, m[1] ? w : {1'b0, w[7:0]}});
                wr(`UA_OFF_ICLR, 32'h1);
            end
        end
        rchk(8'h40, 32'hffffffff, 32'h0);
        chk(r, `UA_RESP_DECERR);
        wr(8'h40, 32'h1);
        chk(r, `UA_RESP_DECERR);
        wr(`UA_OFF_CTRL1, 32'h1);
        chk(r, `UA_RESP_OKAY);
        wr(`UA_OFF_CTRL2, 32'h0b);
        wr(`UA_OFF_DATA, {23'h0, w});
        // Power-down lands mid-frame on both lines
        fork
            serial_node_inst.send(w, 8, 4);
            begin
                repeat (16) @(posedge sys_clk_in);
                wr(`UA_OFF_POWER, 32'h1);
                // Abort lands one edge after power-down is committed
                @(posedge sys_clk_in);
                chk(tx_pin_out, 1'b1);
            end
        join
        serial_node_inst.send(9'h000, 8, 4);
        chk(tx_pin_out, 1'b1);
        chk(power_down_out, 1'b1);
        wr(`UA_OFF_POWER, 32'h0);
        rchk(`UA_OFF_STATUS, 32'h9, 32'h0);
        rchk(`UA_OFF_BAUD, 32'hffff, 32'h3);
        rchk(`UA_OFF_CTRL2, 32'h1f, 32'h0b);
        wr(`UA_OFF_CTRL2, 32'h1b);
        wr(`UA_OFF_IEN, 32'h3);
        wr(`UA_OFF_POWER, 32'h1);
        fork
            serial_node_inst.send(w, 8, 4);
            begin
                n = 0;
                while (power_down_out === 1'b1 && n < 40) begin
                    @(posedge sys_clk_in);
                    n++;
                end
                n = 0;
                while (irq_out !== 1'b1 && n < 1200) begin
                    @(posedge sys_clk_in);
                    n++;
                end
            end
        join
        chk(n >= 1022 && n <= 1032, 1'b1);
        rchk(`UA_OFF_ISTAT, 32'h3, 32'h2);
        rchk(`UA_OFF_STATUS, 32'h1, 32'h0);
        print_verdict;
    end
endmodule : uart_adpd_test
bind uart_adpd uart_adpd_assertions uart_adpd_assertions_inst (.*);
`default_nettype wire
